//--- dv/hpsrw_assertions.sv
module hpsrw_assertions (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [hpsrw_pkg::AXI_DW-1:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic port_cs_n,
  input wire logic port_rw_n,
  input wire logic [hpsrw_pkg::PORT_DATA_BUS_W-1:0] port_data_bus_in,
  input wire logic port_data_bus_oe,
  input wire logic port_acknowledge_out,
  input wire logic host_irq_out_second,
  input wire logic irq_pin_select,
  input wire logic ram_req,
  input wire logic ram_we,
  input wire logic [hpsrw_pkg::AXI_DW-1:0] ram_addr,
  input wire logic [hpsrw_pkg::PORT_DATA_BUS_W-1:0] ram_wdata,
  input wire logic ram_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  import hpsrw_pkg::*;

  // ------------------------------------------------------------
  // Port relations
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  // Answers must not move while the master stalls
  a_bresp_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer moved");
  a_rdata_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer moved");
  a_decerr_zero: assert property (
    s_axi_rvalid && s_axi_rresp == RESP_DECERR |-> s_axi_rdata == 32'h0)
    else $error("refused read not zero");
  // Memory request stays put until answered
  a_ram_req_hold: assert property (
    ram_req && !ram_ack |=> ram_req && $stable(ram_addr))
    else $error("memory request dropped");
  a_ram_cause: assert property (
    $rose(ram_req) |-> !$past(port_cs_n, 2))
    else $error("memory request without host cycle");
  a_ram_dir: assert property (
    $rose(ram_req) |-> ram_we == !port_rw_n)
    else $error("memory direction wrong");
  a_ram_wdata: assert property (
    $rose(ram_req) && ram_we |-> ram_wdata == port_data_bus_in)
    else $error("memory write data wrong");
  // Idle port: acknowledge rests high, data pins released
  a_ack_idle: assert property (
    port_cs_n [*5] |-> port_acknowledge_out && !port_data_bus_oe)
    else $error("acknowledge not idle");
  a_second_idle: assert property (
    !irq_pin_select && !$past(irq_pin_select) |-> host_irq_out_second)
    else $error("second interrupt pin active");
endmodule

bind hpsrw_top hpsrw_assertions i_chk (.*);

//--- dv/hpsrw_ram_model.sv
module hpsrw_ram_model (
  input wire logic clk_sys,
  input wire logic ram_req,
  input wire logic ram_we,
  input wire logic [31:0] ram_addr,
  input wire logic [7:0] ram_wdata,
  output logic ram_ack,
  output logic [7:0] ram_rdata,
  output logic [7:0] n_acc,
  output logic [31:0] last_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [logic [31:0]];
  logic [3:0] wt = 4'h0;

  initial begin
    ram_ack = 1'b0;
    ram_rdata = 8'h5a;
    n_acc = 8'h0;
    last_addr = 32'h0;
  end

  // Odd accesses answer late; data toggles outside an answer
  always @(posedge clk_sys) begin
    ram_ack <= 1'b0;
    ram_rdata <= ~ram_rdata;
    if (ram_req && !ram_ack) begin
      wt <= wt + 4'h1;
      if (wt == {1'b0, n_acc[0], 2'b00}) begin
        wt <= 4'h0;
        ram_ack <= 1'b1;
        n_acc <= n_acc + 8'h1;
        last_addr <= ram_addr;
        ram_rdata <= mem.exists(ram_addr) ? mem[ram_addr] : 8'h00;
        if (ram_we) mem[ram_addr] = ram_wdata;
      end
    end
  end
endmodule

//--- dv/test_host_port_shared_ram_window.sv
module test_host_port_shared_ram_window;
  timeunit 1ns;
  timeprecision 1ps;
  import hpsrw_pkg::*;
  logic clk_sys = 0, rstn = 0, clk_en = 1, irq, s_axi_bvalid, s_axi_rvalid;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready;
  logic s_axi_arready, port_cs_n = 1, port_rw_n = 1, port_data_bus_oe;
  logic port_acknowledge_out, host_irq_out_first, host_irq_out_second;
  logic data_avail_irq_flag = 0, status_irq_flag = 0, irq_pin_select = 0;
  logic host_irq_req = 0, ram_req, ram_we, ram_ack, st;
  logic [4:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, ram_addr, last_addr, rd;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs, strap_addr = 2'b10;
  logic [15:0] port_addr = 0, fifo_mask_status = 16'h3c5a;
  logic [7:0] port_data_bus_in, port_data_bus_out, ram_wdata, ram_rdata;
  logic [7:0] n_acc, q, n0, tb_data = 8'h96;
  logic [3:0] codes [5] = '{SZ_64K, SZ_32K, SZ_16K, SZ_8K, SZ_4K};
  logic [15:0] msk [5] = '{MASK_64K, MASK_32K, MASK_16K, MASK_8K, MASK_4K};
  int n_errors = 0, check_count = 0, cyc = 0, lowc = 0, plen = 0;

  hpsrw_top #(.PULSE_LEN(3)) i_dut (.*);
  hpsrw_ram_model i_ram (.*);

  // Data pins: the port wins while it drives
  assign port_data_bus_in = port_data_bus_oe ? port_data_bus_out : tb_data;

  always #20 clk_sys = ~clk_sys;

  // Length of the latest low pulse on the first host interrupt
  always @(posedge clk_sys) begin
    if (host_irq_out_first === 1'b0) lowc++;
    else if (lowc != 0) begin
      plen = lowc;
      lowc = 0;
    end
  end

  // Hang guard
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      summarize();
    end
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic axi_wr(input logic [4:0] a, input logic [31:0] d,
                        input logic [1:0] er);
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 0;
    chk(s_axi_bresp, er);
  endtask

  task automatic axi_rd(input logic [4:0] a);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 0;
    rd = s_axi_rdata;
    rs = s_axi_rresp;
  endtask

  // Host cycle: style 1 must dip low before the end level
  task automatic hcyc(input logic rw, input logic [15:0] a,
                      input logic [7:0] d);
    @(posedge clk_sys);
    port_rw_n <= rw;
    port_addr <= a;
    tb_data <= d;
    port_cs_n <= 0;
    if (st) while (port_acknowledge_out !== 1'b0) @(posedge clk_sys);
    while (port_acknowledge_out !== st) @(posedge clk_sys);
    if (rw) while (port_data_bus_oe !== 1'b1) @(posedge clk_sys);
    q = port_data_bus_out;
    port_cs_n <= 1;
    tb_data <= ~d;
    repeat (3) @(posedge clk_sys);
    while (port_acknowledge_out !== 1'b1 || port_data_bus_oe !== 1'b0)
      @(posedge clk_sys);
  endtask

  task automatic summarize;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk_sys);
    rstn <= 1;
    repeat (4) @(posedge clk_sys);
    axi_rd(OFF_CTRL);
    chk(rd[1], 1'b1);
    chk(rd[0], 1'b0);
    chk(rd[7], 1'b1);
    axi_rd(OFF_WIN);
    chk(rd, WIN_RESET);
    axi_wr(OFF_WIN, 32'ha5a5_a5a5, RESP_OKAY);
    axi_rd(OFF_WIN);
    chk(rd, 32'ha5a5_a5a5);
    axi_wr(OFF_PULSE, 32'hffff_ffff, RESP_OKAY);
    repeat (8) @(posedge clk_sys);
    chk(plen, 3);
    axi_rd(OFF_PULSE);
    chk(rd[31:16], fifo_mask_status);
    chk(rd[7:0], 8'h96);
    axi_rd(5'h14);
    chk(rs, RESP_DECERR);
    chk(rd, 32'h0);
    axi_wr(5'h14, 32'h1, RESP_DECERR);
    // Host request: pending flag, status, mask, clear
    @(posedge clk_sys);
    host_irq_req <= 1;
    @(posedge clk_sys);
    host_irq_req <= 0;
    axi_rd(OFF_CTRL);
    chk(rd[7], 1'b0);
    chk(irq, 1'b0);
    axi_wr(OFF_IMASK, 32'h1, RESP_OKAY);
    repeat (2) @(posedge clk_sys);
    chk(irq, 1'b1);
    axi_wr(OFF_ISTAT, 32'h1, RESP_OKAY);
    axi_wr(OFF_CTRL, 32'h82, RESP_OKAY);
    repeat (2) @(posedge clk_sys);
    chk(irq, 1'b0);
    axi_rd(OFF_CTRL);
    chk(rd[7], 1'b1);
    // Window closed: cycle completes, nothing reaches memory
    st = 1;
    axi_wr(OFF_WIN, 32'h0001_000f, RESP_OKAY);
    n0 = n_acc;
    hcyc(0, 16'h0005, 8'h77);
    hcyc(1, 16'h0005, 8'h00);
    chk(q, 8'h00);
    chk(n_acc, n0);
    axi_rd(OFF_ISTAT);
    chk(rd[EV_DIS_ACC], 1'b1);
    // Every size code, base a multiple of 64K
    for (int i = 0; i < 5; i++) begin
      if (i == 2) begin
        axi_wr(OFF_CTRL, 32'h80, RESP_OKAY);
        st = 0;
      end
      axi_wr(OFF_WIN, {28'h0001_000, codes[i]}, RESP_OKAY);
      axi_wr(OFF_WIN, {28'h0001_010, codes[i]}, RESP_OKAY);
      hcyc(0, 16'hffff, 8'(i + 1));
      chk(last_addr, 32'h0001_0000 + (16'hffff & msk[i]));
      hcyc(1, 16'hffff & msk[i], 8'h00);
      chk(q, 8'(i + 1));
    end
    // Reserved size code behaves as the smallest window
    axi_wr(OFF_WIN, 32'h0001_0105, RESP_OKAY);
    hcyc(0, 16'hffff, 8'h3c);
    chk(last_addr, 32'h0001_0fff);
    // Flag-driven mode: trigger writes do nothing
    axi_wr(OFF_CTRL, 32'h81, RESP_OKAY);
    plen = 0;
    axi_wr(OFF_PULSE, 32'h0, RESP_OKAY);
    repeat (8) @(posedge clk_sys);
    chk(plen, 0);
    chk(host_irq_out_first, 1'b1);
    for (int k = 0; k < 4; k++) begin
      @(posedge clk_sys);
      irq_pin_select <= k[1];
      data_avail_irq_flag <= k[0];
      status_irq_flag <= !k[0];
      repeat (4) @(posedge clk_sys);
      chk({host_irq_out_first, host_irq_out_second}, {k[1], !k[1]});
      data_avail_irq_flag <= 0;
      status_irq_flag <= 0;
      repeat (4) @(posedge clk_sys);
      chk({host_irq_out_first, host_irq_out_second}, 2'b11);
    end
    summarize();
  end
endmodule

//--- hdl/hpsrw_pkg.sv
package hpsrw_pkg;

  // ----------------------------------------------------------------
  // Register bus geometry
  // ----------------------------------------------------------------
  localparam int AXI_AW = 5;
  localparam int AXI_DW = 32;
  localparam logic [AXI_AW-1:0] OFF_CTRL = 5'h00;
  localparam logic [AXI_AW-1:0] OFF_PULSE = 5'h04;
  localparam logic [AXI_AW-1:0] OFF_WIN = 5'h08;
  localparam logic [AXI_AW-1:0] OFF_ISTAT = 5'h0c;
  localparam logic [AXI_AW-1:0] OFF_IMASK = 5'h10;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_MODE_BIT = 0;
  localparam int CTRL_ACK_BIT = 1;
  localparam int CTRL_PEND_BIT = 7;
  localparam int WIN_EN_BIT = 8;
  localparam int WIN_BASE_LSB = 12;
  localparam int WIN_SIZE_W = 4;
  localparam int JUMPER_W = 8;
  localparam int MIRROR_W = 16;
  localparam int MIRROR_LSB = 16;
  localparam int EV_W = 2;
  localparam int EV_HOST_REQ = 0;
  localparam int EV_DIS_ACC = 1;
  localparam logic [AXI_DW-1:0] WIN_RESET = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Host port geometry and window size codes
  // ----------------------------------------------------------------
  localparam int PADDR_W = 16;
  localparam int PORT_DATA_BUS_W = 8;
  localparam logic [3:0] SZ_64K = 4'h0;
  localparam logic [3:0] SZ_32K = 4'h8;
  localparam logic [3:0] SZ_16K = 4'hc;
  localparam logic [3:0] SZ_8K = 4'he;
  localparam logic [3:0] SZ_4K = 4'hf;
  localparam logic [PADDR_W-1:0] MASK_64K = 16'hffff;
  localparam logic [PADDR_W-1:0] MASK_32K = 16'h7fff;
  localparam logic [PADDR_W-1:0] MASK_16K = 16'h3fff;
  localparam logic [PADDR_W-1:0] MASK_8K = 16'h1fff;
  localparam logic [PADDR_W-1:0] MASK_4K = 16'h0fff;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int PULSE_MIN_NS = 200;
  localparam int PULSE_CYC = (PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PULSE_CW = 4;
  localparam logic [1:0] BOOT_SYNC_CYC = 2'h2;

  // One-hot host port cycle states
  typedef enum logic [2:0] {
    PS_IDLE = 3'b001,
    PS_RAM = 3'b010,
    PS_DONE = 3'b100
  } hpsrw_pstate_t;

endpackage

//--- hdl/hpsrw_top.sv
// Functional notes
// - Ack style 0: acknowledge high during port cycle, low at its end.
// - Ack style 1: acknowledge low at cycle start, high at end for ready.
// - Ack style bit taken at reset from address line one strap.
// - Pulse mode low: pulsed register write pulses first irq low briefly.
// - Pulse mode high: data/status flags drive irq one or two per select.
// - Pulse irq mode bit taken at reset from address line zero strap.
// - Pulsed register stores nothing; triggers only while pulse mode is low.
// - Pulsed register read returns live low 8 port data pins in bits 7:0.
// - Host FIFO mask/status low 16 bits appear in pulsed register bits 31:16.
// - Processor writes never change the mask/status or pulsed register.
// - Window register is 32-bit read/write, zero after reset.
// - RAM address is base plus host index; bits above window size ignored.
// - Window disabled: host accesses complete, writes dropped, reads zero.
// - Window bits 31:12 are the base; base address is field shifted by 12.
// - Size code: 0000 64K, 1000 32K, 1100 16K, 1110 8K, 1111 4K.
// - Pending flag is active low, cleared by writing one to bit 7.
module hpsrw_top #(
  parameter int PULSE_LEN = hpsrw_pkg::PULSE_CYC
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic [hpsrw_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [hpsrw_pkg::AXI_DW-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [hpsrw_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [hpsrw_pkg::AXI_DW-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq,
  input wire logic [1:0] strap_addr,
  input wire logic port_cs_n,
  input wire logic port_rw_n,
  input wire logic [hpsrw_pkg::PADDR_W-1:0] port_addr,
  input wire logic [hpsrw_pkg::PORT_DATA_BUS_W-1:0] port_data_bus_in,
  output logic [hpsrw_pkg::PORT_DATA_BUS_W-1:0] port_data_bus_out,
  output logic port_data_bus_oe,
  output logic port_acknowledge_out,
  output logic host_irq_out_first,
  output logic host_irq_out_second,
  input wire logic data_avail_irq_flag,
  input wire logic status_irq_flag,
  input wire logic irq_pin_select,
  input wire logic host_irq_req,
  input wire logic [hpsrw_pkg::MIRROR_W-1:0] fifo_mask_status,
  output logic ram_req,
  output logic ram_we,
  output logic [hpsrw_pkg::AXI_DW-1:0] ram_addr,
  output logic [hpsrw_pkg::PORT_DATA_BUS_W-1:0] ram_wdata,
  input wire logic ram_ack,
  input wire logic [hpsrw_pkg::PORT_DATA_BUS_W-1:0] ram_rdata
);
  import hpsrw_pkg::*;

  // ----------------------------------------------------------------
  // State record
  // ----------------------------------------------------------------
  typedef struct packed {
    logic cs_s1;
    logic cs_s2;
    logic rw_s1;
    logic rw_s2;
    logic [PADDR_W-1:0] addr_s1;
    logic [PADDR_W-1:0] addr_s2;
    logic [PORT_DATA_BUS_W-1:0] din_s1;
    logic [PORT_DATA_BUS_W-1:0] din_s2;
    logic [1:0] strap_s1;
    logic [1:0] strap_s2;
    logic [1:0] boot_cnt;
    logic ack_style_select;
    logic pulse_irq_mode;
    logic irq_pending_flag;
    logic [AXI_DW-1:0] win;
    logic [EV_W-1:0] istat;
    logic [EV_W-1:0] imask;
    logic irq;
    logic [PULSE_CW-1:0] pulse_cnt;
    logic irq_first;
    logic irq_second;
    hpsrw_pstate_t pst;
    logic ack;
    logic [PORT_DATA_BUS_W-1:0] dout;
    logic doe;
    logic ram_req;
    logic ram_we;
    logic [AXI_DW-1:0] ram_addr;
    logic [PORT_DATA_BUS_W-1:0] ram_wdata;
    logic aw_held;
    logic [AXI_AW-1:0] aw_addr;
    logic w_held;
    logic [AXI_DW-1:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [AXI_DW-1:0] rdata;
  } hpsrw_state_t;

  hpsrw_state_t s_r;
  hpsrw_state_t s_nxt;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // index mask, reserved as 4K
  function automatic logic [PADDR_W-1:0] size_mask(input logic [3:0] code);
    case (code)
      SZ_64K: size_mask = MASK_64K;
      SZ_32K: size_mask = MASK_32K;
      SZ_16K: size_mask = MASK_16K;
      SZ_8K: size_mask = MASK_8K;
      SZ_4K: size_mask = MASK_4K;
      default: size_mask = MASK_4K;
    endcase
  endfunction

  // Byte-lane merge for register writes
  function automatic logic [AXI_DW-1:0] merge(input logic [AXI_DW-1:0] old,
      input logic [AXI_DW-1:0] data, input logic [3:0] strb);
    merge = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        merge[i*8 +: 8] = data[i*8 +: 8];
      end
    end
  endfunction

  function automatic logic offset_known(input logic [AXI_AW-1:0] a);
    offset_known = (a == OFF_CTRL) || (a == OFF_PULSE) || (a == OFF_WIN) ||
      (a == OFF_ISTAT) || (a == OFF_IMASK);
  endfunction

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic [EV_W-1:0] ev;
    logic do_wr;
    logic [PADDR_W-1:0] idx;
    logic [AXI_DW-1:0] rd;
    logic pulse_on;
    logic lvl;
    ev = '0;
    do_wr = 1'b0;
    idx = '0;
    rd = '0;
    pulse_on = 1'b0;
    lvl = 1'b0;
    s_nxt = s_r;

    // Pin synchronisers; only stage two is read beyond this point
    s_nxt.cs_s1 = port_cs_n;
    s_nxt.cs_s2 = s_r.cs_s1;
    s_nxt.rw_s1 = port_rw_n;
    s_nxt.rw_s2 = s_r.rw_s1;
    s_nxt.addr_s1 = port_addr;
    s_nxt.addr_s2 = s_r.addr_s1;
    s_nxt.din_s1 = port_data_bus_in;
    s_nxt.din_s2 = s_r.din_s1;
    s_nxt.strap_s1 = strap_addr;
    s_nxt.strap_s2 = s_r.strap_s1;

    // Bootstrap capture once the strap synchroniser has filled
    if (s_r.boot_cnt != BOOT_SYNC_CYC) begin
      s_nxt.boot_cnt = s_r.boot_cnt + 2'h1;
    end
    if (s_r.boot_cnt == BOOT_SYNC_CYC - 2'h1) begin
      s_nxt.ack_style_select = s_r.strap_s2[1];
      s_nxt.pulse_irq_mode = s_r.strap_s2[0];
    end

    // Host port cycle sequencer
    case (s_r.pst)
      PS_IDLE: begin
        s_nxt.ack = 1'b1;
        s_nxt.doe = 1'b0;
        if (!s_r.cs_s2 && s_r.boot_cnt == BOOT_SYNC_CYC) begin
          // acknowledge level while the cycle runs
          s_nxt.ack = !s_r.ack_style_select;
          idx = s_r.addr_s2 & size_mask(s_r.win[WIN_SIZE_W-1:0]);
          s_nxt.ram_addr = {s_r.win[AXI_DW-1:WIN_BASE_LSB],
            {WIN_BASE_LSB{1'b0}}} + {{(AXI_DW-PADDR_W){1'b0}}, idx};
          if (s_r.win[WIN_EN_BIT]) begin
            s_nxt.ram_req = 1'b1;
            s_nxt.ram_we = !s_r.rw_s2;
            s_nxt.ram_wdata = s_r.din_s2;
            s_nxt.pst = PS_RAM;
          end else begin
            // finish without RAM, read gives zeros
            s_nxt.dout = '0;
            ev[EV_DIS_ACC] = 1'b1;
            s_nxt.pst = PS_DONE;
          end
        end
      end
      PS_RAM: begin
        if (ram_ack) begin
          s_nxt.ram_req = 1'b0;
          s_nxt.dout = s_r.ram_we ? '0 : ram_rdata;
          s_nxt.pst = PS_DONE;
        end
      end
      PS_DONE: begin
        s_nxt.ack = s_r.ack_style_select;
        s_nxt.doe = s_r.rw_s2;
        if (s_r.cs_s2) begin
          s_nxt.ack = 1'b1;
          s_nxt.doe = 1'b0;
          s_nxt.pst = PS_IDLE;
        end
      end
      default: begin
        s_nxt.pst = PS_IDLE;
        s_nxt.ram_req = 1'b0;
      end
    endcase

    // AXI4-Lite write side: address and data taken in either order
    if (s_r.aw_held == 1'b0 && s_axi_awvalid) begin
      s_nxt.aw_held = 1'b1;
      s_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_r.w_held == 1'b0 && s_axi_wvalid) begin
      s_nxt.w_held = 1'b1;
      s_nxt.w_data = s_axi_wdata;
      s_nxt.w_strb = s_axi_wstrb;
    end
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end
    do_wr = s_r.aw_held && s_r.w_held && !s_r.bvalid;
    if (do_wr) begin
      s_nxt.aw_held = 1'b0;
      s_nxt.w_held = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = offset_known(s_r.aw_addr) ? RESP_OKAY : RESP_DECERR;
      case (s_r.aw_addr)
        OFF_CTRL: begin
          if (s_r.w_strb[0]) begin
            s_nxt.pulse_irq_mode = s_r.w_data[CTRL_MODE_BIT];
            s_nxt.ack_style_select = s_r.w_data[CTRL_ACK_BIT];
            // write one clears pending (back to high)
            if (s_r.w_data[CTRL_PEND_BIT]) begin
              s_nxt.irq_pending_flag = 1'b1;
            end
          end
        end
        OFF_PULSE: begin
          // no storage, only a trigger in pulse mode
          if (!s_r.pulse_irq_mode) begin
            pulse_on = 1'b1;
          end
        end
        OFF_WIN: begin
          s_nxt.win = merge(s_r.win, s_r.w_data, s_r.w_strb);
        end
        OFF_ISTAT: begin
          if (s_r.w_strb[0]) begin
            s_nxt.istat = s_r.istat & ~s_r.w_data[EV_W-1:0];
          end
        end
        OFF_IMASK: begin
          if (s_r.w_strb[0]) begin
            s_nxt.imask = s_r.w_data[EV_W-1:0];
          end
        end
        default: begin
          s_nxt.bresp = RESP_DECERR;
        end
      endcase
    end

    // AXI4-Lite read side; one read in flight at a time
    if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !s_r.rvalid) begin
      case (s_axi_araddr)
        OFF_CTRL: begin
          rd[CTRL_MODE_BIT] = s_r.pulse_irq_mode;
          rd[CTRL_ACK_BIT] = s_r.ack_style_select;
          rd[CTRL_PEND_BIT] = s_r.irq_pending_flag;
        end
        OFF_PULSE: begin
          rd[JUMPER_W-1:0] = s_r.din_s2[JUMPER_W-1:0];
          rd[MIRROR_LSB +: MIRROR_W] = fifo_mask_status;
        end
        OFF_WIN: rd = s_r.win;
        OFF_ISTAT: rd[EV_W-1:0] = s_r.istat;
        OFF_IMASK: rd[EV_W-1:0] = s_r.imask;
        default: rd = '0;
      endcase
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata = rd;
      s_nxt.rresp = offset_known(s_axi_araddr) ? RESP_OKAY : RESP_DECERR;
    end

    // Host request: set wins over a same-cycle clear
    if (host_irq_req) begin
      s_nxt.irq_pending_flag = 1'b0;
      ev[EV_HOST_REQ] = 1'b1;
    end

    // Sticky events, mask, one level output
    s_nxt.istat = s_nxt.istat | ev;
    s_nxt.irq = |(s_nxt.istat & s_nxt.imask);

    // Pulse stretcher for the edge-style host interrupt
    if (pulse_on) begin
      s_nxt.pulse_cnt = PULSE_CW'(PULSE_LEN);
    end else if (s_r.pulse_cnt != '0) begin
      s_nxt.pulse_cnt = s_r.pulse_cnt - 1'b1;
    end
    if (s_r.pulse_irq_mode) begin
      // level interrupt steered by the pin select
      lvl = data_avail_irq_flag | status_irq_flag;
      s_nxt.irq_first = !(lvl && !irq_pin_select);
      s_nxt.irq_second = !(lvl && irq_pin_select);
      s_nxt.pulse_cnt = '0;
    end else begin
      // pulse on the first output only
      s_nxt.irq_first = (s_nxt.pulse_cnt == '0);
      s_nxt.irq_second = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Strap synchroniser runs through reset so boot capture sees real pins
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      s_r <= '0;
      s_r.cs_s1 <= 1'b1;
      s_r.cs_s2 <= 1'b1;
      s_r.rw_s1 <= 1'b1;
      s_r.rw_s2 <= 1'b1;
      s_r.strap_s1 <= strap_addr;
      s_r.strap_s2 <= s_r.strap_s1;
      s_r.irq_pending_flag <= 1'b1;
      s_r.win <= WIN_RESET;
      s_r.irq_first <= 1'b1;
      s_r.irq_second <= 1'b1;
      s_r.pst <= PS_IDLE;
      s_r.ack <= 1'b1;
    end else if (clk_en) begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all straight from the state register
  // ----------------------------------------------------------------
  assign s_axi_awready = !s_r.aw_held;
  assign s_axi_wready = !s_r.w_held;
  assign s_axi_bvalid = s_r.bvalid;
  assign s_axi_bresp = s_r.bresp;
  assign s_axi_arready = !s_r.rvalid;
  assign s_axi_rvalid = s_r.rvalid;
  assign s_axi_rresp = s_r.rresp;
  assign s_axi_rdata = s_r.rdata;
  assign irq = s_r.irq;
  assign port_data_bus_out = s_r.dout;
  assign port_data_bus_oe = s_r.doe;
  assign port_acknowledge_out = s_r.ack;
  assign host_irq_out_first = s_r.irq_first;
  assign host_irq_out_second = s_r.irq_second;
  assign ram_req = s_r.ram_req;
  assign ram_we = s_r.ram_we;
  assign ram_addr = s_r.ram_addr;
  assign ram_wdata = s_r.ram_wdata;

endmodule
